/* rtl/wdg_pkg.sv */
// Constants, option byte layout and shared helpers of the windowed watchdog.
// Assumes a byte-wide CPU register port and a single system clock.
package wdg_pkg;

    // Register map and codes.
    localparam logic [15:0] WDG_RESTART_ADDR = 16'hFF99;
    localparam logic [7:0]  WDG_RESTART_CODE = 8'hAC;
    localparam logic [7:0]  WDG_RST_VAL_ON   = 8'h9A;
    localparam logic [7:0]  WDG_RST_VAL_OFF  = 8'h1A;
    localparam logic [15:0] WDG_EXEMPT_LO    = 16'hFB00;
    localparam logic [15:0] WDG_EXEMPT_HI    = 16'hFFFF;

    // Option byte field positions.
    localparam int WDG_OPT_LOCK_BIT = 0;
    localparam int WDG_OPT_OVF_LSB  = 1;
    localparam int WDG_OPT_OVF_MSB  = 3;
    localparam int WDG_OPT_EN_BIT   = 4;
    localparam int WDG_OPT_WIN_LSB  = 5;
    localparam int WDG_OPT_WIN_MSB  = 6;

    // Counter geometry: code 0 gives 2^10 low-speed periods, code 7 gives 2^17.
    localparam int WDG_CNT_W       = 17;
    localparam int WDG_OVF_MIN_EXP = 10;
    localparam int WDG_QTR_SHIFT   = 2;

    typedef logic [WDG_CNT_W-1:0] wdg_cnt_t;

    // Window codes: open part of the period, closed part precedes it.
    localparam logic [1:0] WDG_WIN_25  = 2'h0;
    localparam logic [1:0] WDG_WIN_50  = 2'h1;
    localparam logic [1:0] WDG_WIN_75  = 2'h2;
    localparam logic [1:0] WDG_WIN_100 = 2'h3;

    // Last count value before overflow for an overflow select code.
    function automatic wdg_cnt_t wdg_last_cnt(input logic [2:0] sel);
        logic [WDG_CNT_W:0] per;
        per = (WDG_CNT_W+1)'(1) << (WDG_OVF_MIN_EXP + int'(sel));
        per = per - (WDG_CNT_W+1)'(1);
        return per[WDG_CNT_W-1:0];
    endfunction : wdg_last_cnt

endpackage : wdg_pkg

/* rtl/wdg_cnt_if.sv */
// Link between the watchdog control logic and its period counter.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface wdg_cnt_if;
    import wdg_pkg::*;
    logic       tick;
    logic       run;
    logic       clr;
    logic [2:0] ovf_sel;
    logic [1:0] win_sel;
    wdg_cnt_t   count;
    logic       ovf;
    logic       win_open;

    modport ctl (output tick, run, clr, ovf_sel, win_sel,
                 input  count, ovf, win_open);
    modport cnt (input  tick, run, clr, ovf_sel, win_sel,
                 output count, ovf, win_open);
endinterface : wdg_cnt_if

/* rtl/wdg_counter.sv */
// Period counter of the watchdog: counts low-speed ticks, flags overflow
// and tells whether the restart window is open.
// Assumes tick is a one-cycle pulse per low-speed clock period.
`timescale 1ns/10ps
module wdg_counter (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Control side
    wdg_cnt_if.cnt   cif
);
    import wdg_pkg::*;

    typedef struct packed {
        wdg_cnt_t cnt;
    } wdg_cnt_s;

    wdg_cnt_s cnt_ff;
    wdg_cnt_s nxt_cnt;
    wdg_cnt_t last;
    wdg_cnt_t qtr;
    wdg_cnt_t closed_lim;

    always_comb begin
        last = wdg_last_cnt(cif.ovf_sel);
        qtr  = (last >> WDG_QTR_SHIFT) + wdg_cnt_t'(1);
        unique case (cif.win_sel)
            WDG_WIN_25:  closed_lim = (qtr << 1) + qtr;
            WDG_WIN_50:  closed_lim = qtr << 1;
            WDG_WIN_75:  closed_lim = qtr;
            WDG_WIN_100: closed_lim = '0;
        endcase
    end

    // A clear in the last tick wins over the overflow of that tick.
    assign cif.ovf      = cif.tick & cif.run & ~cif.clr & (cnt_ff.cnt == last);
    assign cif.win_open = (cnt_ff.cnt >= closed_lim);
    assign cif.count    = cnt_ff.cnt;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (cif.clr) begin
            nxt_cnt.cnt = '0;
        end else if (cif.tick && cif.run) begin
            // Overflow wraps to zero; the system reset follows anyway.
            nxt_cnt.cnt = (cnt_ff.cnt == last) ? '0 : cnt_ff.cnt + wdg_cnt_t'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

endmodule : wdg_counter

/* rtl/wdg_top.sv */
// Windowed watchdog: option capture, restart register, error detection
// and internal reset request.
// Assumes the CPU port, option byte and power-mode inputs are on clk_sys;
// the low-speed oscillator arrives as an asynchronous level.
//
// What this block does
// - Restart register holds 9A with counting enabled, 1A when disabled.
// - Any code other than AC resets; deferred while the source clock stops.
// - Single-bit access to the restart register resets; deferred likewise.
// - Reads return the fixed reset value, never the written code.
// - Enable option bit turns on counting and illegal-access detection.
// - Software writes AC before overflow; that clears and restarts the count.
// - From the second write on, writing in the closed window resets.
// - Overflow without a valid restart causes an internal reset.
// - Fetch from an unconfigured area resets when detection is on.
// - Data access to an unconfigured area resets, FB00 to FFFF exempt.
// - First write after reset restarts the count regardless of window.
// - Restart may bring the effective overflow forward by up to one low-speed period.
// - A restart just before the terminal count still prevents overflow.
// - Without oscillator lock counting pauses in HALT and STOP.
// - Without lock, the oscillator-stop bit freezes the count uncleared.
// - Counting continues through flash self-programming.
// - Overflow select codes 0 to 7 give 2^10 to 2^17 low-speed periods.
// - Window code picks the final 25, 50, 75 or 100 percent as open.
// - A watchdog reset sets the watchdog reset flag.
`timescale 1ns/10ps
module wdg_top (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Option byte from the loader
    input  wire logic [7:0]  opt_byte,
    // Low-speed oscillator clock, asynchronous
    input  wire logic        lsclk_in,
    // Power modes and oscillator control
    input  wire logic        halt_mode,
    input  wire logic        stop_mode,
    input  wire logic        low_speed_osc_stop,
    // CPU register port
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        reg_bitop,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    // Access monitor
    input  wire logic        fetch_vld,
    input  wire logic        fetch_area_ok,
    input  wire logic        acc_vld,
    input  wire logic [15:0] acc_addr,
    input  wire logic        acc_area_ok,
    // Reset flag clear and reset outputs
    input  wire logic        flag_clr,
    output logic             wdt_rst_req,
    output logic             watchdog_reset_flag
);
    import wdg_pkg::*;

    typedef struct packed {
        logic       ls_s1;
        logic       ls_s2;
        logic       ls_s3;
        logic       opt_vld;
        logic       count_enable_option;
        logic [2:0] overflow_select;
        logic [1:0] open_period_select;
        logic       low_speed_osc_lock;
        logic [7:0] restart_val;
        logic       first_done;
        logic       pend;
        logic       rst_req;
        logic       flag;
        logic [7:0] rdata;
    } wdg_top_s;

    wdg_top_s st_ff;
    wdg_top_s nxt_st;

    wdg_cnt_if cif ();

    wdg_counter u_counter (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .cif     (cif)
    );

    logic reg_hit;
    logic wr_hit;
    logic good_code;
    logic code_err;
    logic bit_err;
    logic win_err;
    logic valid_restart;
    logic fetch_err;
    logic acc_exempt;
    logic acc_err;
    logic any_err;
    logic clk_run;
    logic cnt_run;
    logic detect_on;

    // The source clock only stops when software may stop it.
    assign clk_run = st_ff.low_speed_osc_lock | ~low_speed_osc_stop;

    // Flash self-programming has no input here: counting never pauses for it.
    assign cnt_run = st_ff.opt_vld & st_ff.count_enable_option
                   & (st_ff.low_speed_osc_lock
                      | ~(halt_mode | stop_mode | low_speed_osc_stop));

    assign detect_on = st_ff.opt_vld & st_ff.count_enable_option;

    assign reg_hit   = (reg_wr | reg_rd) & (reg_addr == WDG_RESTART_ADDR);
    assign wr_hit    = reg_wr & (reg_addr == WDG_RESTART_ADDR);
    assign good_code = (reg_wdata == WDG_RESTART_CODE);

    assign code_err = wr_hit & ~reg_bitop & ~good_code;
    assign bit_err  = reg_hit & reg_bitop;

    // Window is only policed once the first write after reset is done.
    assign win_err = wr_hit & ~reg_bitop & good_code & cnt_run
                   & st_ff.first_done & ~cif.win_open;

    assign valid_restart = wr_hit & ~reg_bitop & good_code & ~win_err;

    assign fetch_err  = detect_on & fetch_vld & ~fetch_area_ok;
    assign acc_exempt = (acc_addr >= WDG_EXEMPT_LO) & (acc_addr <= WDG_EXEMPT_HI);
    assign acc_err    = detect_on & acc_vld & ~acc_area_ok & ~acc_exempt;

    assign any_err = code_err | bit_err | win_err | fetch_err | acc_err | cif.ovf;

    // Counter control.
    assign cif.tick    = st_ff.ls_s2 & ~st_ff.ls_s3;
    assign cif.run     = cnt_run;
    // Clearing the count does not realign the tick phase, so the period seen
    // after a restart may be shorter than the nominal one by up to one tick.
    assign cif.clr     = valid_restart & cnt_run;
    assign cif.ovf_sel = st_ff.overflow_select;
    assign cif.win_sel = st_ff.open_period_select;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ls_s1 = lsclk_in;
        nxt_st.ls_s2 = st_ff.ls_s1;
        nxt_st.ls_s3 = st_ff.ls_s2;

        if (!st_ff.opt_vld) begin
            nxt_st.opt_vld             = 1'b1;
            nxt_st.count_enable_option = opt_byte[WDG_OPT_EN_BIT];
            nxt_st.overflow_select     = opt_byte[WDG_OPT_OVF_MSB:WDG_OPT_OVF_LSB];
            nxt_st.open_period_select  = opt_byte[WDG_OPT_WIN_MSB:WDG_OPT_WIN_LSB];
            nxt_st.low_speed_osc_lock  = opt_byte[WDG_OPT_LOCK_BIT];
            nxt_st.restart_val = opt_byte[WDG_OPT_EN_BIT] ? WDG_RST_VAL_ON
                                                          : WDG_RST_VAL_OFF;
        end

        if (wr_hit) begin
            nxt_st.first_done = 1'b1;
        end

        if (reg_rd && reg_addr == WDG_RESTART_ADDR) begin
            nxt_st.rdata = st_ff.restart_val;
        end

        // Errors wait here while the low-speed clock is stopped.
        nxt_st.rst_req = (st_ff.pend | any_err) & clk_run;
        nxt_st.pend    = (st_ff.pend | any_err) & ~clk_run;

        // A new reset event wins over a clear in the same cycle.
        nxt_st.flag = (st_ff.flag & ~flag_clr) | nxt_st.rst_req;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '{restart_val: WDG_RST_VAL_ON, rdata: WDG_RST_VAL_ON,
                       default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata           = st_ff.rdata;
    assign wdt_rst_req         = st_ff.rst_req;
    assign watchdog_reset_flag = st_ff.flag;

    // ---------------------------------------------------------------
    // Checks of the documented behaviour.
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    localparam int HOLD_LO = 1;
    localparam int HOLD_HI = 2;

    property p_err_to_req(ev);
        ev && clk_run |=> wdt_rst_req;
    endproperty

    init_value_a: assert property (
        $rose(st_ff.opt_vld) |->
            st_ff.restart_val == (st_ff.count_enable_option ? WDG_RST_VAL_ON
                                                            : WDG_RST_VAL_OFF))
        else $error("restart register value wrong after option capture");

    bad_code_a: assert property (p_err_to_req(code_err))
        else $error("wrong restart code did not request reset");

    bit_access_a: assert property (p_err_to_req(bit_err))
        else $error("single-bit access did not request reset");

    defer_reset_a: assert property (
        (st_ff.pend && !clk_run) |=> !wdt_rst_req)
        else $error("reset issued while source clock stopped");

    read_value_a: assert property (
        reg_rd && reg_addr == WDG_RESTART_ADDR && st_ff.opt_vld
        |=> reg_rdata == $past(st_ff.restart_val) && reg_rdata != WDG_RESTART_CODE)
        else $error("restart register read did not return fixed value");

    restart_clear_a: assert property (
        cif.clr |=> cif.count == '0 ##[HOLD_LO:HOLD_HI] 1'b1)
        else $error("valid restart did not clear counter");

    late_restart_a: assert property (
        cif.clr && cif.tick && cif.count == wdg_last_cnt(cif.ovf_sel)
        |=> !wdt_rst_req || $past((any_err && !cif.ovf) || st_ff.pend))
        else $error("restart at terminal count did not prevent overflow");

    overflow_a: assert property (
        cif.ovf && clk_run |=> wdt_rst_req)
        else $error("overflow did not request reset");

    closed_window_a: assert property (
        wr_hit && good_code && !reg_bitop && cnt_run && st_ff.first_done
        && !cif.win_open && clk_run |=> wdt_rst_req)
        else $error("write in closed window did not request reset");

    first_write_a: assert property (
        wr_hit && good_code && !reg_bitop && cnt_run && !st_ff.first_done
        |=> cif.count == '0)
        else $error("first restart did not clear counter");

    fetch_check_a: assert property (
        detect_on && fetch_vld && !fetch_area_ok && clk_run |=> wdt_rst_req)
        else $error("illegal fetch not detected");

    exempt_area_a: assert property (
        acc_vld && !acc_area_ok && acc_exempt && !fetch_err && !st_ff.pend
        && !(code_err | bit_err | win_err | cif.ovf) |=> !wdt_rst_req)
        else $error("access to exempt area raised reset");

    detect_off_a: assert property (
        !detect_on |-> !fetch_err && !acc_err && !cif.run)
        else $error("detection or counting active while disabled");

    pause_hold_a: assert property (
        !cif.run && !cif.clr |=> $stable(cif.count))
        else $error("counter moved while paused");

    flag_set_a: assert property (
        wdt_rst_req |-> watchdog_reset_flag)
        else $error("reset flag not set on watchdog reset");

    option_hold_a: assert property (
        st_ff.opt_vld |=> $stable(st_ff.overflow_select)
                          && $stable(st_ff.open_period_select)
                          && $stable(st_ff.count_enable_option))
        else $error("option settings changed after capture");

    // The checks below watch the restart value, the window, the counter controls, access detection,
    // the reset request and the reset flag, where a wrong pause or a lost flag would only show after a long count.
    off_value_a: assert property (
        st_ff.opt_vld && !st_ff.count_enable_option
        |-> st_ff.restart_val == WDG_RST_VAL_OFF)
        else $error("restart register value wrong with counting disabled");

    open_write_a: assert property (
        wr_hit && good_code && !reg_bitop && cnt_run && cif.win_open
        |=> cif.count == '0)
        else $error("restart in open window did not clear counter");

    full_window_a: assert property (
        st_ff.open_period_select == WDG_WIN_100
        |-> cif.win_open)
        else $error("window closed although fully open was selected");

    closed_start_a: assert property (
        cif.count == '0 && st_ff.open_period_select != WDG_WIN_100
        |-> !cif.win_open)
        else $error("window open at start of period");

    count_step_a: assert property (
        cif.tick && cif.run && !cif.clr && !cif.ovf
        |=> cif.count == $past(cif.count) + wdg_cnt_t'(1))
        else $error("counter did not advance on a tick");

    halt_pause_a: assert property (
        !st_ff.low_speed_osc_lock && (halt_mode || stop_mode)
        |-> !cif.run)
        else $error("counter ran in a power-down mode without lock");

    lock_run_a: assert property (
        st_ff.low_speed_osc_lock && detect_on
        |-> cif.run)
        else $error("locked counter stopped");

    osc_stop_a: assert property (
        !st_ff.low_speed_osc_lock && low_speed_osc_stop
        |-> !cif.run)
        else $error("counter ran with the oscillator stopped");

    access_err_a: assert property (
        detect_on && acc_vld && !acc_area_ok && !acc_exempt && clk_run
        |=> wdt_rst_req)
        else $error("illegal data access not detected");

    pend_capture_a: assert property (
        any_err && !clk_run
        |=> st_ff.pend)
        else $error("error not kept while source clock stopped");

    req_pulse_a: assert property (
        wdt_rst_req && !any_err
        |=> !wdt_rst_req)
        else $error("reset request longer than one cycle");

    flag_hold_a: assert property (
        watchdog_reset_flag && !flag_clr
        |=> watchdog_reset_flag)
        else $error("reset flag dropped without a clear");

    flag_wins_a: assert property (
        flag_clr && (any_err || st_ff.pend) && clk_run
        |=> watchdog_reset_flag)
        else $error("flag clear won over a new watchdog reset");

    restart_cov: cover property (cif.clr && cif.win_open && st_ff.first_done);
    overflow_cov: cover property (cif.ovf ##1 wdt_rst_req);
    defer_cov: cover property (st_ff.pend && !clk_run ##1 clk_run ##1 wdt_rst_req);
    window_cov: cover property (win_err);
    lock_cov: cover property (st_ff.low_speed_osc_lock && halt_mode && cif.tick);

endmodule : wdg_top

/* tb/wdg_cpu_model.sv */
// Behavioural CPU core that drives the watchdog register port and access monitor.
// Assumes the bench calls its tasks one at a time on the system clock.
`timescale 1ns/10ps
module wdg_cpu_model (
    // Clock
    input  wire logic   clk_sys,
    // Register port
    output logic [15:0] reg_addr,
    output logic        reg_wr,
    output logic        reg_rd,
    output logic        reg_bitop,
    output logic [7:0]  reg_wdata,
    // Access monitor
    output logic        fetch_vld,
    output logic        fetch_area_ok,
    output logic        acc_vld,
    output logic [15:0] acc_addr,
    output logic        acc_area_ok
);
    initial begin
        {reg_wr, reg_rd, reg_bitop, fetch_vld, acc_vld} = '0;
        {reg_addr, acc_addr, reg_wdata} = '0;
        {fetch_area_ok, acc_area_ok} = 2'h3;
    end

    // Idle lines show inverted values, so a stale address never looks valid.
    task automatic reg_op(input logic [15:0] a, input logic [7:0] d, input logic wr,
                          input logic bop);
        @(posedge clk_sys);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = wr;
        reg_rd    = ~wr;
        reg_bitop = bop;
        @(posedge clk_sys);
        #1;
        {reg_wr, reg_rd, reg_bitop} = '0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : reg_op

    task automatic mon_op(input logic fch, input logic [15:0] a, input logic ok);
        @(posedge clk_sys);
        #1;
        fetch_vld     = fch;
        acc_vld       = ~fch;
        acc_addr      = a;
        fetch_area_ok = ok;
        acc_area_ok   = ok;
        @(posedge clk_sys);
        #1;
        {fetch_vld, acc_vld} = '0;
        acc_addr      = ~a;
        fetch_area_ok = ~ok;
        acc_area_ok   = ~ok;
    endtask : mon_op
endmodule : wdg_cpu_model

/* tb/test_windowed_watchdog.sv */
// Self-checking bench of the windowed watchdog.
// Assumes the CPU model drives the register port; the bench acts as reset controller.
`timescale 1ns/10ps
module test_windowed_watchdog;
    import wdg_pkg::*;
    localparam int LS = 6;
    logic        clk_sys, rst_b, lsclk_in, ls_hold, flag_clr;
    logic        halt_mode, stop_mode, low_speed_osc_stop;
    logic [7:0]  opt_byte, reg_wdata, reg_rdata;
    logic [15:0] reg_addr, acc_addr;
    logic        reg_wr, reg_rd, reg_bitop, fetch_vld, fetch_area_ok, acc_vld, acc_area_ok;
    logic        wdt_rst_req, watchdog_reset_flag;
    int          failures = 0;
    int          n_checks = 0;
    int          n_req    = 0;

    wdg_cpu_model u_cpu (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_bitop(reg_bitop), .reg_wdata(reg_wdata),
        .fetch_vld(fetch_vld), .fetch_area_ok(fetch_area_ok), .acc_vld(acc_vld),
        .acc_addr(acc_addr), .acc_area_ok(acc_area_ok));
    wdg_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .opt_byte(opt_byte),
        .lsclk_in(lsclk_in), .halt_mode(halt_mode), .stop_mode(stop_mode),
        .low_speed_osc_stop(low_speed_osc_stop), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_bitop(reg_bitop), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .fetch_vld(fetch_vld), .fetch_area_ok(fetch_area_ok),
        .acc_vld(acc_vld), .acc_addr(acc_addr), .acc_area_ok(acc_area_ok),
        .flag_clr(flag_clr), .wdt_rst_req(wdt_rst_req),
        .watchdog_reset_flag(watchdog_reset_flag));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // The low-speed clock is kept 1 ns off the system edges, at a fixed phase to clk_sys.
    initial begin
        lsclk_in = 1'b0;
        #1;
        forever begin
            #12;
            if (!ls_hold) lsclk_in = ~lsclk_in;
        end
    end
    always @(posedge clk_sys) if (wdt_rst_req === 1'b1) n_req <= n_req + 1;

    task automatic check_byte(input string w, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask : check_byte
    task automatic check_bit(input string w, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %b seen %b", w, e, g);
        end
    endtask : check_bit
    task automatic check_cnt(input string w, input int e, input int g);
        n_checks++;
        if (g != e) begin
            failures++;
            $display("wrong value %s expected %0d seen %0d", w, e, g);
        end
    endtask : check_cnt
    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    task automatic do_reset(input logic [7:0] opt);
        @(posedge clk_sys);
        #1;
        rst_b    = 1'b0;
        opt_byte = opt;
        repeat (5) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : do_reset
    task automatic wr(input logic [7:0] d, input logic bop);
        u_cpu.reg_op(WDG_RESTART_ADDR, d, 1'b1, bop);
    endtask : wr
    task automatic expect_req(input string w, input int cyc, input int e);
        int base;
        base = n_req;
        repeat (cyc) @(posedge clk_sys);
        #1;
        check_cnt(w, e, n_req - base);
    endtask : expect_req
    task automatic wait_req(input string w, input int quiet, input int lim);
        int base;
        expect_req(w, quiet, 0);
        base = n_req;
        for (int i = 0; i < lim && n_req == base; i++) begin
            @(posedge clk_sys);
            #1;
        end
        check_cnt(w, 1, n_req - base);
        if (n_req == base) print_verdict();
    endtask : wait_req

    task automatic t_regs();
        do_reset(8'h30);
        opt_byte = 8'h20;
        u_cpu.reg_op(WDG_RESTART_ADDR, 8'h00, 1'b0, 1'b0);
        check_byte("read on", 8'h9A, reg_rdata);
        wr(8'hAC, 1'b0);
        u_cpu.reg_op(WDG_RESTART_ADDR, 8'h00, 1'b0, 1'b0);
        check_byte("read after code", 8'h9A, reg_rdata);
        do_reset(8'h20);
        u_cpu.reg_op(WDG_RESTART_ADDR, 8'h00, 1'b0, 1'b0);
        check_byte("read off", 8'h1A, reg_rdata);
        u_cpu.mon_op(1'b1, 16'h1000, 1'b0);
        u_cpu.mon_op(1'b0, 16'h1000, 1'b0);
        expect_req("off count", 1100 * LS, 0);
        wr(8'h55, 1'b0);
        expect_req("off code", 4, 1);
    endtask : t_regs

    task automatic t_errors();
        do_reset(8'h30);
        wr(8'h55, 1'b0);
        expect_req("bad code", 4, 1);
        check_bit("flag set", 1'b1, watchdog_reset_flag);
        flag_clr = 1'b1;
        @(posedge clk_sys);
        #1;
        flag_clr = 1'b0;
        check_bit("flag clr", 1'b0, watchdog_reset_flag);
        do_reset(8'h30);
        wr(8'hAC, 1'b1);
        expect_req("bit op", 4, 1);
        do_reset(8'h30);
        u_cpu.mon_op(1'b1, 16'h2000, 1'b0);
        expect_req("fetch", 4, 1);
        do_reset(8'h30);
        u_cpu.mon_op(1'b0, 16'hFB00, 1'b0);
        u_cpu.mon_op(1'b0, 16'hFFFF, 1'b0);
        u_cpu.mon_op(1'b0, 16'h1000, 1'b1);
        expect_req("exempt", 4, 0);
        u_cpu.mon_op(1'b0, 16'hFAFF, 1'b0);
        expect_req("access", 4, 1);
    endtask : t_errors

    task automatic t_deferred();
        do_reset(8'h30);
        low_speed_osc_stop = 1'b1;
        ls_hold            = 1'b1;
        wr(8'h55, 1'b0);
        expect_req("held", 40, 0);
        low_speed_osc_stop = 1'b0;
        ls_hold            = 1'b0;
        expect_req("resumed", 12, 1);
    endtask : t_deferred

    task automatic t_window();
        do_reset(8'h30);
        wr(8'hAC, 1'b0);
        expect_req("first", 600 * LS, 0);
        wr(8'hAC, 1'b0);
        expect_req("open", 4, 0);
        wait_req("overflow", 1018 * LS, 14 * LS);
        check_bit("ovf flag", 1'b1, watchdog_reset_flag);
        do_reset(8'h12);
        wr(8'hAC, 1'b0);
        expect_req("quarter", 1400 * LS, 0);
        wr(8'hAC, 1'b0);
        expect_req("closed", 4, 1);
        do_reset(8'h50);
        wr(8'hAC, 1'b0);
        expect_req("early", 200 * LS, 0);
        wr(8'hAC, 1'b0);
        expect_req("three quarter closed", 4, 1);
        expect_req("three quarter wait", 80 * LS, 0);
        wr(8'hAC, 1'b0);
        expect_req("three quarter open", 4, 0);
    endtask : t_window

    task automatic t_power();
        // A count left half way must resume, not restart, after each pause.
        do_reset(8'h30);
        expect_req("run", 500 * LS, 0);
        halt_mode = 1'b1;
        expect_req("halt", 1200 * LS, 0);
        halt_mode = 1'b0;
        stop_mode = 1'b1;
        expect_req("stop", 200 * LS, 0);
        stop_mode = 1'b0;
        low_speed_osc_stop = 1'b1;
        expect_req("osc stop", 200 * LS, 0);
        low_speed_osc_stop = 1'b0;
        wait_req("resume", 518 * LS, 14 * LS);
        halt_mode = 1'b1;
        do_reset(8'h73);
        wait_req("locked", 2042 * LS, 14 * LS);
        halt_mode = 1'b0;
    endtask : t_power

    initial begin
        {rst_b, ls_hold, flag_clr, halt_mode, stop_mode, low_speed_osc_stop} = '0;
        opt_byte = 8'h30;
        t_regs();
        t_errors();
        t_deferred();
        t_window();
        t_power();
        print_verdict();
    end
endmodule : test_windowed_watchdog
